// *** src/tsense_defines.svh ***
`ifndef TSENSE_DEFINES_SVH
`define TSENSE_DEFINES_SVH
// ==========================================================
// Register indices; byte address is four times the index.
`define TS_IDX_LOCAL    6'h00
`define TS_IDX_RMT_MSB  6'h01
`define TS_IDX_STATUS   6'h02
`define TS_IDX_CONFIG   6'h03
`define TS_IDX_RHS_MSB  6'h07
`define TS_IDX_RLS_MSB  6'h08
`define TS_IDX_RMT_LSB  6'h10
`define TS_IDX_RHS_LSB  6'h13
`define TS_IDX_RLS_LSB  6'h14
`define TS_IDX_CRIT     6'h19
`define TS_IDX_FILTER   6'h1A
// ==========================================================
// Reset values.
`define TS_RST_CONFIG   8'h00
`define TS_RST_RHS_MSB  8'h69
`define TS_RST_RLS_MSB  8'h00
`define TS_RST_LSB      8'h00
`define TS_RST_CRIT     8'h55
`define TS_RST_FILTER   8'h00
// ==========================================================
// Field positions.
`define TS_CFG_QUEUE    0
`define TS_CFG_MASK     7
`define TS_FLT_UNSIGNED 2
// ==========================================================
// Filter select codes.
`define TS_FILT_NONE    2'h0
`define TS_FILT_STD     2'h1
`define TS_FILT_ENH     2'h3
// ==========================================================
// Remote temperatures in 1/32 degree units, 16-bit signed; local ones in whole degrees.
`define TS_S_MIN        16'hF000
`define TS_S_MAX        16'h0FFF
`define TS_U_MAX        16'h1FFF
`define TS_F_NEG128     16'hF000
`define TS_F_POS127     16'h0FE0
`define TS_F_POS255     16'h1FE0
`define TS_CLIP         16'h0040
`define TS_LOC_MAX      10'h07F
`define TS_LOC_MIN      10'h380
`define TS_LOC_SAT_HI   8'h7F
`define TS_LOC_SAT_LO   8'h80
`define TS_QUEUE_DEPTH  2'h3
`define TS_RESP_OKAY    2'h0
`define TS_RESP_SLVERR  2'h2
`endif

// *** src/tsense_pkg.sv ***
package tsense_pkg;
   typedef struct packed {
      logic rhigh;
      logic rlow;
      logic fault;
      logic rcrit;
   } status_t;
endpackage

// *** src/temp_result_format_and_fault.sv ***
// Overview of operation
// - Temperatures are readable only through the local and remote value registers.
// - Remote value is a left-justified 16-bit word; unused low bits read zero.
// - Out-of-range temperatures clamp at full scale, never wrap.
// - Unfiltered remote reading and high limit use 11 bits, 0.125 degree step.
// - Filtered remote reading uses 13 bits, 0.03125 degree step.
// - Local reading and critical limit are 8-bit signed, one degree step.
// - Critical limit may also be 8-bit unsigned.
// - Attention and critical outputs only pull low or release.
// - Grounded diode forces -128 signed, 0 unsigned.
// - Open or supply-shorted diode forces 127 or 255 and sets fault flag.
// - Fault flag alone never drives attention or critical output.
// - Limit comparisons use the forced reading during a diode fault.
// - Registers are read only, write only, or read/write.
// - Serial data bytes go most significant bit first.
// - Read may end with acknowledge or not-acknowledge.
// - Filter select: 00 none, 01 standard, 10 reserved, 11 enhanced clipping.
// - Filter adds no offset to the remote reading.
// - With queue on, limit events need three consecutive out-of-limit readings; a critical limit event still sets on the first.
// - Queue is off after reset; software sets its enable bit.
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "tsense_defines.svh"
`default_nettype none
module temp_result_format_and_fault (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   input  wire logic        conv_done,
   input  wire logic [9:0]  local_raw,
   input  wire logic [15:0] remote_raw,
   input  wire logic        diode_gnd_pin,
   input  wire logic        diode_open_pin,
   output logic             attention_o,
   output logic             attention_oe,
   output logic             critical_output_o,
   output logic             critical_output_oe
);
   // =======================================================
   // Registers and state
   logic [7:0]  cfg_r, rhs_msb_r, rls_msb_r, rhs_lsb_r, rls_lsb_r;
   logic [7:0]  crit_r, filt_cfg_r, local_r;
   logic [15:0] rmt_word_r, filt_r;
   logic [1:0]  gnd_sy_r, open_sy_r, hi_cnt_r, lo_cnt_r;
   tsense_pkg::status_t st_r;
   logic        aw_have_r, w_have_r;
   logic [7:0]  aw_addr_r;
   logic [7:0]  w_data_r;
   logic        w_lane_r;
   logic        rd_clr;
   // =======================================================
   // Diode fault pins come from the analog side.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         gnd_sy_r  <= 2'h0;
         open_sy_r <= 2'h0;
      end else if (ce) begin
         gnd_sy_r  <= {gnd_sy_r[0], diode_gnd_pin};
         open_sy_r <= {open_sy_r[0], diode_open_pin};
      end
   end
   wire gnd_s  = gnd_sy_r[1];
   wire open_s = open_sy_r[1];
   wire uns    = filt_cfg_r[`TS_FLT_UNSIGNED];
   wire [1:0] fsel = filt_cfg_r[1:0];
   wire filt_on = (fsel == `TS_FILT_STD) || (fsel == `TS_FILT_ENH);
   // =======================================================
   // Remote filter. The step never rounds to zero while an
   // error remains, so the output settles on the input exactly.
   logic [15:0] diff, diff_c, step;
   always_comb begin
      diff   = remote_raw - filt_r;
      diff_c = diff;
      if (fsel == `TS_FILT_ENH) begin
         if ($signed(diff) > $signed(`TS_CLIP))
            diff_c = `TS_CLIP;
         else if ($signed(diff) < -$signed(`TS_CLIP))
            diff_c = -`TS_CLIP;
      end
      step = {{2{diff_c[15]}}, diff_c[15:2]};
      if (step == 16'h0000 && diff_c != 16'h0000)
         step = diff_c[15] ? 16'hFFFF : 16'h0001;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         filt_r <= 16'h0000;
      else if (ce && conv_done)
         filt_r <= filt_on ? filt_r + step : remote_raw;
   end
   // =======================================================
   // Effective reading, forced on a fault, then clamped.
   logic [15:0] t_src, t_eff;
   always_comb begin
      t_src = filt_on ? filt_r + step : remote_raw;
      if (gnd_s)
         t_src = uns ? 16'h0000 : `TS_F_NEG128;
      else if (open_s)
         t_src = uns ? `TS_F_POS255 : `TS_F_POS127;
      t_eff = t_src;
      if (uns) begin
         if ($signed(t_src) < 0)
            t_eff = 16'h0000;
         else if ($signed(t_src) > $signed(`TS_U_MAX))
            t_eff = `TS_U_MAX;
      end else begin
         if ($signed(t_src) < $signed(`TS_F_NEG128))
            t_eff = `TS_S_MIN;
         else if ($signed(t_src) > $signed(`TS_S_MAX))
            t_eff = `TS_S_MAX;
      end
   end
   // Left-justify 13 bits; without the filter only 11 are kept.
   wire [15:0] word_full = {t_eff[12:0], 3'h0};
   wire [15:0] rmt_word  = filt_on ? word_full : {word_full[15:5], 5'h00};
   // =======================================================
   // Limits in the same 1/32 degree units.
   wire [2:0]  hs = uns ? 3'h0 : {3{rhs_msb_r[7]}};
   wire [2:0]  ls = uns ? 3'h0 : {3{rls_msb_r[7]}};
   wire [2:0]  cs = uns ? 3'h0 : {3{crit_r[7]}};
   wire [15:0] hi_lim = {hs, rhs_msb_r, rhs_lsb_r[7:5], 2'h0};
   wire [15:0] lo_lim = {ls, rls_msb_r, rls_lsb_r[7:5], 2'h0};
   wire [15:0] cr_lim = {cs, crit_r, 5'h00};
   wire rmt_hi = $signed(t_eff) > $signed(hi_lim);
   wire rmt_lo = $signed(t_eff) < $signed(lo_lim);
   wire rmt_cr = $signed(t_eff) > $signed(cr_lim);
   wire q_en   = cfg_r[`TS_CFG_QUEUE];
   wire hi_ev  = rmt_hi && (!q_en || hi_cnt_r == `TS_QUEUE_DEPTH - 2'h1);
   wire lo_ev  = rmt_lo && (!q_en || lo_cnt_r == `TS_QUEUE_DEPTH - 2'h1);
   // =======================================================
   // Results latch per conversion.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         local_r    <= 8'h00;
         rmt_word_r <= 16'h0000;
      end else if (ce && conv_done) begin
         rmt_word_r <= rmt_word;
         if ($signed(local_raw) > $signed(`TS_LOC_MAX))
            local_r <= `TS_LOC_SAT_HI;
         else if ($signed(local_raw) < $signed(`TS_LOC_MIN))
            local_r <= `TS_LOC_SAT_LO;
         else
            local_r <= local_raw[7:0];
      end
   end
   // Counters saturate one below the depth; the event fires on the third.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hi_cnt_r <= 2'h0;
         lo_cnt_r <= 2'h0;
      end else if (ce && conv_done) begin
         hi_cnt_r <= !rmt_hi ? 2'h0 : (hi_ev ? hi_cnt_r : hi_cnt_r + 2'h1);
         lo_cnt_r <= !rmt_lo ? 2'h0 : (lo_ev ? lo_cnt_r : lo_cnt_r + 2'h1);
      end
   end
   // Sticky flags clear on a status read; a new event wins.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         st_r <= '0;
      else if (ce) begin
         st_r.rhigh <= (st_r.rhigh && !rd_clr) || (conv_done && hi_ev);
         st_r.rlow  <= (st_r.rlow && !rd_clr) || (conv_done && lo_ev);
         st_r.fault <= (st_r.fault && !rd_clr) || (conv_done && open_s);
         st_r.rcrit <= (st_r.rcrit && !rd_clr) || (conv_done && rmt_cr);
      end
   end
   // The fault flag is left out of both pin terms on purpose.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         attention_o        <= 1'b0;
         attention_oe       <= 1'b0;
         critical_output_o  <= 1'b0;
         critical_output_oe <= 1'b0;
      end else if (ce) begin
         attention_oe <= (st_r.rhigh || st_r.rlow || st_r.rcrit)
                         && !cfg_r[`TS_CFG_MASK];
         critical_output_oe <= st_r.rcrit;
      end
   end
   // =======================================================
   // AXI4-Lite write path
   wire do_wr = aw_have_r && w_have_r && !bvalid;
   wire [5:0] widx = aw_addr_r[7:2];
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 8'h00;
         w_lane_r  <= 1'b0;
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= `TS_RESP_OKAY;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= awaddr;
            awready   <= 1'b0;
         end
         if (wvalid && wready) begin
            w_have_r <= 1'b1;
            w_data_r <= wdata[7:0];
            w_lane_r <= wstrb[0];
            wready   <= 1'b0;
         end
         if (do_wr) begin
            bvalid <= 1'b1;
            case (widx)
               `TS_IDX_LOCAL, `TS_IDX_RMT_MSB, `TS_IDX_STATUS, `TS_IDX_CONFIG,
               `TS_IDX_RHS_MSB, `TS_IDX_RLS_MSB, `TS_IDX_RMT_LSB, `TS_IDX_RHS_LSB,
               `TS_IDX_RLS_LSB, `TS_IDX_CRIT, `TS_IDX_FILTER:
                  bresp <= `TS_RESP_OKAY;
               default:
                  bresp <= `TS_RESP_SLVERR;
            endcase
         end
         if (bvalid && bready) begin
            bvalid    <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awready   <= 1'b1;
            wready    <= 1'b1;
         end
      end
   end
   // Read-only registers ignore writes and still answer OKAY.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r      <= `TS_RST_CONFIG;
         rhs_msb_r  <= `TS_RST_RHS_MSB;
         rls_msb_r  <= `TS_RST_RLS_MSB;
         rhs_lsb_r  <= `TS_RST_LSB;
         rls_lsb_r  <= `TS_RST_LSB;
         crit_r     <= `TS_RST_CRIT;
         filt_cfg_r <= `TS_RST_FILTER;
      end else if (ce && do_wr && w_lane_r) begin
         case (widx)
            `TS_IDX_CONFIG:  cfg_r      <= {w_data_r[7], 6'h00, w_data_r[0]};
            `TS_IDX_RHS_MSB: rhs_msb_r  <= w_data_r;
            `TS_IDX_RLS_MSB: rls_msb_r  <= w_data_r;
            `TS_IDX_RHS_LSB: rhs_lsb_r  <= {w_data_r[7:5], 5'h00};
            `TS_IDX_RLS_LSB: rls_lsb_r  <= {w_data_r[7:5], 5'h00};
            `TS_IDX_CRIT:    crit_r     <= w_data_r;
            `TS_IDX_FILTER:  filt_cfg_r <= {5'h00, w_data_r[2:0]};
            default: ;
         endcase
      end
   end
   // =======================================================
   // AXI4-Lite read path, one cycle from address to data.
   wire [5:0] ridx = araddr[7:2];
   assign rd_clr = arvalid && arready && (ridx == `TS_IDX_STATUS);
   logic [7:0] rd_val;
   logic       rd_bad;
   always_comb begin
      rd_bad = 1'b0;
      case (ridx)
         `TS_IDX_LOCAL:   rd_val = local_r;
         `TS_IDX_RMT_MSB: rd_val = rmt_word_r[15:8];
         `TS_IDX_RMT_LSB: rd_val = rmt_word_r[7:0];
         `TS_IDX_STATUS:  rd_val = {3'h0, st_r.rhigh, st_r.rlow, st_r.fault,
                                    st_r.rcrit, 1'b0};
         `TS_IDX_CONFIG:  rd_val = cfg_r;
         `TS_IDX_RHS_MSB: rd_val = rhs_msb_r;
         `TS_IDX_RLS_MSB: rd_val = rls_msb_r;
         `TS_IDX_RHS_LSB: rd_val = rhs_lsb_r;
         `TS_IDX_RLS_LSB: rd_val = rls_lsb_r;
         `TS_IDX_CRIT:    rd_val = crit_r;
         `TS_IDX_FILTER:  rd_val = filt_cfg_r;
         default: begin
            rd_val = 8'h00;
            rd_bad = 1'b1;
         end
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= `TS_RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h000000, rd_val};
            rresp   <= rd_bad ? `TS_RESP_SLVERR : `TS_RESP_OKAY;
         end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
   // =======================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_low_zero;
      rmt_word_r[2:0] == 3'h0;
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("low bits not zero");
   property p_unfilt;
      ce && conv_done && fsel == `TS_FILT_NONE |=> rmt_word_r[4:0] == 5'h00;
   endproperty
   a_unfilt: assert property (p_unfilt) else $error("unfiltered lsb wrong");
   property p_local_sat;
      ce && conv_done && $signed(local_raw) > 200 |=> local_r == 8'h7F;
   endproperty
   a_local_sat: assert property (p_local_sat) else $error("local wrapped");
   property p_gnd;
      ce && conv_done && gnd_s && !uns |=> rmt_word_r == 16'h8000;
   endproperty
   a_gnd: assert property (p_gnd) else $error("ground force wrong");
   property p_open;
      ce && conv_done && open_s && !gnd_s && uns
         |=> rmt_word_r == 16'hFF00 && st_r.fault;
   endproperty
   a_open: assert property (p_open) else $error("open force wrong");
   property p_fault_quiet;
      ce && !st_r.rhigh && !st_r.rlow && !st_r.rcrit |=> !attention_oe && !critical_output_oe;
   endproperty
   a_fault_quiet: assert property (p_fault_quiet) else $error("fault drove pin");
   property p_od;
      !attention_o && !critical_output_o;
   endproperty
   a_od: assert property (p_od) else $error("pin driven high");
   property p_queue;
      ce && conv_done && q_en && hi_cnt_r == 2'h0 && !st_r.rhigh ##1 !rd_clr
         |-> !st_r.rhigh;
   endproperty
   a_queue: assert property (p_queue) else $error("queue fired early");
   property p_cnt_clr;
      ce && conv_done && !rmt_hi |=> hi_cnt_r == 2'h0;
   endproperty
   a_cnt_clr: assert property (p_cnt_clr) else $error("counter kept");
   property p_crit_pin;
      ce |=> critical_output_oe == $past(st_r.rcrit);
   endproperty
   a_crit_pin: assert property (p_crit_pin) else $error("critical pin lost status");
   property p_mask;
      ce && cfg_r[`TS_CFG_MASK] |=> !attention_oe;
   endproperty
   a_mask: assert property (p_mask) else $error("masked attention driven");
   property p_uns_floor;
      ce && conv_done && uns && !filt_on && !gnd_s && !open_s && $signed(remote_raw) < 0
         |=> rmt_word_r == 16'h0000;
   endproperty
   a_uns_floor: assert property (p_uns_floor) else $error("unsigned reading wrapped");
   property p_read_only;
      ce && do_wr && widx == `TS_IDX_LOCAL && !conv_done |=> $stable(local_r);
   endproperty
   a_read_only: assert property (p_read_only) else $error("read-only register written");
   property p_queue_third;
      ce && conv_done && q_en && rmt_hi && hi_cnt_r == 2'h2 |=> st_r.rhigh;
   endproperty
   a_queue_third: assert property (p_queue_third) else $error("third reading missed");
   property p_rd_done;
      ce && rvalid && rready |=> !rvalid && arready;
   endproperty
   a_rd_done: assert property (p_rd_done) else $error("read not closed");
endmodule // temp_result_format_and_fault
`default_nettype wire

// *** test/axi_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module axi_host_model (
   input  wire logic        clk_sys,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [7:0]       awaddr,
   output logic             wvalid,
   input  wire logic        wready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   input  wire logic        bvalid,
   output logic             bready,
   input  wire logic [1:0]  bresp,
   output logic             arvalid,
   input  wire logic        arready,
   output logic [7:0]       araddr,
   input  wire logic        rvalid,
   output logic             rready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp
);
   initial begin
      awvalid = 1'b0;
      awaddr  = 8'h00;
      wvalid  = 1'b0;
      wdata   = 32'h00000000;
      wstrb   = 4'h0;
      bready  = 1'b0;
      arvalid = 1'b0;
      araddr  = 8'h00;
      rready  = 1'b0;
   end
   // ==========================================================
   // Register access.
   // A released address or data bus shows the inverse of its last value, so that
   // the slave cannot quietly rely on a stale payload.
   task automatic write_reg(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] resp);
      logic aw_left;
      logic w_left;
      @(posedge clk_sys);
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h000000, d};
      wstrb   <= 4'h1;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      aw_left = 1'b1;
      w_left  = 1'b1;
      while (aw_left || w_left) begin
         @(posedge clk_sys);
         if (aw_left && awready) begin
            aw_left = 1'b0;
            awvalid <= 1'b0;
            awaddr  <= ~awaddr;
         end
         if (w_left && wready) begin
            w_left = 1'b0;
            wvalid <= 1'b0;
            wdata  <= ~wdata;
         end
      end
      do @(posedge clk_sys); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic read_reg(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
      @(posedge clk_sys);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      araddr  <= ~araddr;
      do @(posedge clk_sys); while (rvalid !== 1'b1);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
endmodule // axi_host_model
`default_nettype wire

// *** test/temp_result_format_and_fault_bench.sv ***
`timescale 1ns/1ns
`include "tsense_defines.svh"
`default_nettype none
module temp_result_format_and_fault_bench;
   logic        clk_sys;
   logic        rst_b;
   logic        ce;
   logic        conv_done;
   logic [9:0]  local_raw;
   logic [15:0] remote_raw;
   logic        diode_gnd_pin;
   logic        diode_open_pin;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        attention_o, attention_oe, critical_output_o, critical_output_oe;
   logic [31:0] rd;
   logic [1:0]  rs;
   logic        hit;
   int          errors = 0;
   int          samples_checked = 0;
   int          cycle_count = 0;
   int          seed;
   int          lr;
   int          rr;
   bit          outs [$];
   logic [5:0]  reset_idx [7] = '{`TS_IDX_STATUS, `TS_IDX_CONFIG, `TS_IDX_RHS_MSB, `TS_IDX_RLS_MSB,
                                  `TS_IDX_RHS_LSB, `TS_IDX_CRIT, `TS_IDX_FILTER};
   logic [7:0]  reset_val [7] = '{8'h00, `TS_RST_CONFIG, `TS_RST_RHS_MSB, `TS_RST_RLS_MSB,
                                  `TS_RST_LSB, `TS_RST_CRIT, `TS_RST_FILTER};
   logic [7:0]  cfg_tbl [3] = '{8'h00, 8'h01, 8'h80};
   bit          pattern [7] = '{0, 1, 1, 0, 1, 1, 1};
   logic [27:0] fault_tbl [4] = '{28'h17F0006, 28'h2800008, 28'h6000000, 28'h5FF0016};

   temp_result_format_and_fault i_temp_result_format_and_fault (
      .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .conv_done(conv_done), .local_raw(local_raw), .remote_raw(remote_raw),
      .diode_gnd_pin(diode_gnd_pin), .diode_open_pin(diode_open_pin),
      .attention_o(attention_o), .attention_oe(attention_oe),
      .critical_output_o(critical_output_o), .critical_output_oe(critical_output_oe));
   axi_host_model i_axi_host_model (
      .clk_sys(clk_sys), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

   always #5 clk_sys = ~clk_sys;
   // ==========================================================
   // Reference model and helpers.
   function automatic logic [15:0] exp_word(input int raw, input bit uns, input bit filt);
      int c;
      if (uns) c = (raw < 0) ? 0 : ((raw > 8191) ? 8191 : raw);
      else c = (raw < -4096) ? -4096 : ((raw > 4095) ? 4095 : raw);
      c = c * 8;
      return filt ? c[15:0] : (c[15:0] & 16'hFFE0);
   endfunction
   function automatic logic [7:0] exp_local(input int raw);
      int c;
      c = (raw < -128) ? -128 : ((raw > 127) ? 127 : raw);
      return c[7:0];
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (exp !== seen) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
      i_axi_host_model.read_reg(idx, rd, rs);
      check("read data", {24'h000000, exp}, rd);
      check("read resp", {30'h0, `TS_RESP_OKAY}, {30'h0, rs});
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      i_axi_host_model.write_reg(idx, d, rs);
      check("write resp", {30'h0, `TS_RESP_OKAY}, {30'h0, rs});
   endtask
   task automatic rd_remote(input logic [15:0] w);
      rd_chk(`TS_IDX_RMT_MSB, w[15:8]);
      rd_chk(`TS_IDX_RMT_LSB, w[7:0]);
   endtask
   // Status lands on the pulse edge and the pins one edge later, so two spare edges suffice.
   task automatic convert(input int l, input int r);
      @(posedge clk_sys);
      local_raw  <= l[9:0];
      remote_raw <= r[15:0];
      conv_done  <= 1'b1;
      @(posedge clk_sys);
      conv_done <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycle_count++;
      if (cycle_count == 20000) begin
         errors++;
         complete_run();
      end
   end
   // ==========================================================
   // Main sequence.
   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      ce = 1'b1;
      conv_done = 1'b0;
      local_raw = 10'h000;
      remote_raw = 16'h0000;
      diode_gnd_pin = 1'b0;
      diode_open_pin = 1'b0;
      seed = 32'hC5089448;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      foreach (reset_idx[i]) rd_chk(reset_idx[i], reset_val[i]);
      i_axi_host_model.read_reg(6'h3F, rd, rs);
      check("unmapped data", 32'h00000000, rd);
      check("unmapped resp", {30'h0, `TS_RESP_SLVERR}, {30'h0, rs});
      for (int f = 0; f < 4; f++) begin
         wr(`TS_IDX_FILTER, 8'(f));
         rd_chk(`TS_IDX_FILTER, 8'(f));
         repeat (300) convert(20, 1234 + f * 97);
         rd_remote(exp_word(1234 + f * 97, 1'b0, f[0]));
      end
      // A conversion offered while the enable is low must leave every result untouched.
      ce <= 1'b0;
      convert(20, -300);
      ce <= 1'b1;
      rd_remote(exp_word(1234 + 3 * 97, 1'b0, 1'b1));
      for (int i = 0; i < 12; i++) begin
         lr = $random(seed) % 300;
         rr = $random(seed) % 9000;
         wr(`TS_IDX_FILTER, {5'h00, i[0], 2'h0});
         convert(lr, rr);
         wr(`TS_IDX_LOCAL, 8'hA5);
         rd_chk(`TS_IDX_LOCAL, exp_local(lr));
         rd_remote(exp_word(rr, i[0], 1'b0));
      end
      wr(`TS_IDX_CRIT, 8'h96);
      rd_chk(`TS_IDX_CRIT, 8'h96);
      wr(`TS_IDX_RHS_MSB, `TS_RST_RHS_MSB);
      wr(`TS_IDX_RHS_LSB, 8'h00);
      foreach (cfg_tbl[k]) begin
         wr(`TS_IDX_CONFIG, cfg_tbl[k]);
         rd_chk(`TS_IDX_CONFIG, cfg_tbl[k]);
         i_axi_host_model.read_reg(`TS_IDX_STATUS, rd, rs);
         outs = {};
         foreach (pattern[j]) begin
            convert(20, pattern[j] ? 3520 : 800);
            outs.push_back(pattern[j]);
            hit = cfg_tbl[k][0] ? (outs.size() >= 3 && outs[$] && outs[$-1] && outs[$-2])
                                : pattern[j];
            check("attention enable", !cfg_tbl[k][7] && hit, attention_oe);
            rd_chk(`TS_IDX_STATUS, hit ? 8'h10 : 8'h00);
         end
      end
      wr(`TS_IDX_CONFIG, 8'h00);
      wr(`TS_IDX_RHS_MSB, 8'h7F);
      wr(`TS_IDX_RHS_LSB, 8'hE0);
      foreach (fault_tbl[k]) begin
         wr(`TS_IDX_FILTER, {5'h00, fault_tbl[k][26], 2'h0});
         diode_gnd_pin  <= fault_tbl[k][25];
         diode_open_pin <= fault_tbl[k][24];
         repeat (4) @(posedge clk_sys);
         convert(20, 800);
         rd_remote(fault_tbl[k][23:8]);
         check("attention enable", |(fault_tbl[k][7:0] & 8'h1A), attention_oe);
         check("critical enable", fault_tbl[k][1], critical_output_oe);
         rd_chk(`TS_IDX_STATUS, fault_tbl[k][7:0]);
      end
      check("attention data", 32'h0, {31'h0, attention_o});
      check("critical data", 32'h0, {31'h0, critical_output_o});
      complete_run();
   end
endmodule // temp_result_format_and_fault_bench
`default_nettype wire
